/* hdl/port_maint_pkg.sv */
package port_maint_pkg;

  // ==========================================================
  // register offsets
  localparam logic [15:0] MAINT_CONTROL_STATUS_OFS = 16'h001c;
  localparam logic [15:0] PORT_DIAG_FAIL_TEST_OFS  = 16'h0020;
  localparam logic [15:0] PORT_STATUS_WORD_OFS     = 16'h0024;
  localparam logic [15:0] QUEUE_BLOCK_BASE_OFS     = 16'h1000;
  localparam logic [15:0] STATUS_RELEASE_OFS       = 16'h1038;
  localparam logic [15:0] PORT_INIT_OFS            = 16'h1044;

  // ==========================================================
  // maintenance register fields
  localparam int MCS_INIT_BIT      = 0;
  localparam int MCS_TMR_DIS_BIT   = 1;
  localparam int MCS_IRQ_EN_BIT    = 2;
  localparam int MCS_NORESP_BIT    = 4;
  localparam int MCS_PROCESSOR_ERROR_STATUS_FLAG_BIT     = 5;
  localparam int MCS_RDERR_BIT     = 6;
  localparam int MCS_WRERR_BIT     = 7;
  localparam int MCS_UCODE_LO      = 8;
  localparam int MCS_UCODE_HI      = 13;
  localparam int MCS_PB_IB_RX_BIT  = 14;
  localparam int MCS_DP_PB_RD_BIT  = 15;
  localparam int MCS_MOV_REG_BIT   = 16;
  localparam int MCS_MOVA_WR_BIT   = 17;
  localparam int MCS_MOVB_RD_BIT   = 18;
  // error bits <30:21,18:04>
  localparam logic [31:0] MCS_ERR_MASK  = 32'h7fe7_fff0;
  localparam logic [31:0] MCS_CTRL_MASK = 32'h0000_0006;

  // ==========================================================
  // port status word fields
  localparam int PSW_RESP_AVAIL_BIT = 0;
  localparam int PSW_MFQ_EMPTY_BIT  = 1;
  localparam int PSW_DSE_BIT        = 4;
  localparam int PSW_MSE_BIT        = 5;
  localparam int PSW_TMR_EXP_BIT    = 6;
  localparam int PSW_MISC_BIT       = 7;
  localparam int PSW_MIF_BIT        = 8;
  localparam int PSW_UNINIT_BIT     = 10;
  localparam int PSW_SUMMARY_BIT    = 31;
  localparam logic [31:0] PSW_SUM_MASK = 32'h0000_04fe;
  // status bits that microcode may set: 10 and 8..0
  localparam logic [31:0] PSW_SET_MASK = 32'h0000_05ff;

  // ==========================================================
  // reset values and timing
  localparam logic [31:0] MCS_RESET = 32'h0000_0000;
  localparam logic [31:0] PSW_RESET = 32'h0000_0400;
  localparam int PROCESSOR_ERROR_STATUS_FLAG_CYCLES  = 32;
  localparam int NORESP_CYCLES = 512;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic movb_pb_rd;
    logic mova_pb_wr;
    logic mov_reg_rd;
    logic dp_pb_rd;
    logic port_internal_bus_rx;
  } par_err_t;

  typedef struct packed {
    logic       set_wr;
    logic [5:0] set_ucode;
    logic       wr_err_irq;
    logic       rd_err_resp;
    logic       diag_load;
    logic [7:0] diag_num;
    logic [31:0] psw_set;
    logic       enter_enabled;
    logic       enter_disabled;
    logic       ucode_init;
    logic       boot_timeout;
  } ucode_req_t;

endpackage : port_maint_pkg

/* hdl/sticky_bit.sv */
module sticky_bit
  import port_maint_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      q_o
);

  logic bit_reg;
  logic bit_next;

  // set wins over a clear in the same cycle
  always_comb
  begin
    bit_next = bit_reg;
    if (clr_i)
      bit_next = 1'b0;
    if (set_i)
      bit_next = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      bit_reg <= 1'b0;
    else
      bit_reg <= bit_next;
  end

  assign q_o = bit_reg;

endmodule : sticky_bit

/* hdl/hold_timer.sv */
module hold_timer
  import port_maint_pkg::*;
#(
  parameter int LIMIT = 32
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic run_i,
  // result
  output logic      fire_o
);

  localparam int W = $clog2(LIMIT + 2);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // counts consecutive cycles of run_i; fires once past the limit
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!run_i)
      cnt_next = '0;
    else if (cnt_reg <= LIM)
      cnt_next = cnt_reg + W'(1);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign fire_o = run_i && (cnt_reg == LIM);

endmodule : hold_timer

/* hdl/port_maint_status_regs.sv */
module port_maint_status_regs
  import port_maint_pkg::*;
#(
  parameter int PROCESSOR_ERROR_STATUS_FLAG_LIMIT  = PROCESSOR_ERROR_STATUS_FLAG_CYCLES,
  parameter int NORESP_LIMIT = NORESP_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // host register access
  input  wire reg_req_t   req_i,
  output logic [31:0]     rdata_o,
  // hardware error detectors
  input  wire par_err_t   par_err_i,
  input  wire logic       processor_error_signal_i,
  input  wire logic       resp_irq_pending_i,
  input  wire logic       resp_irq_ack_i,
  input  wire logic       sanity_expired_i,
  // microcode requests
  input  wire ucode_req_t ucode_i,
  // outputs
  output logic            bus_error_summary_o,
  output logic            node_err_summary_o,
  output logic            status_irq_o,
  output logic            sanity_hold_o,
  output logic            port_reset_o
);

  // ==========================================================
  // decode
  logic wr_mcs;
  logic wr_release;
  logic wr_init;
  logic wr_qbb;
  logic maint_init;
  logic soft_rst;

  assign wr_mcs     = req_i.wr && req_i.addr == MAINT_CONTROL_STATUS_OFS;
  assign wr_release = req_i.wr && req_i.addr == STATUS_RELEASE_OFS;
  assign wr_init    = req_i.wr && req_i.addr == PORT_INIT_OFS;
  assign wr_qbb     = req_i.wr && req_i.addr == QUEUE_BLOCK_BASE_OFS;
  assign maint_init = wr_mcs && req_i.wdata[MCS_INIT_BIT];

  // maintenance init acts one cycle later as a clear of everything except the read data register
  logic init_reg;
  logic init_next;
  always_comb
  begin
    init_next = maint_init;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      init_reg <= 1'b0;
    else
      init_reg <= init_next;
  end
  assign soft_rst     = rst_i | init_reg;
  assign port_reset_o = init_reg;

  // ==========================================================
  // timers
  logic processor_error_status_flag_fire;
  logic noresp_fire;

  hold_timer #(.LIMIT(PROCESSOR_ERROR_STATUS_FLAG_LIMIT)) u_processor_error_status_flag_timer (
    .clk_i  (clk_i),
    .rst_i  (soft_rst),
    .run_i  (processor_error_signal_i),
    .fire_o (processor_error_status_flag_fire)
  );

  hold_timer #(.LIMIT(NORESP_LIMIT - 1)) u_noresp_timer (
    .clk_i  (clk_i),
    .rst_i  (soft_rst),
    .run_i  (resp_irq_pending_i && !resp_irq_ack_i),
    .fire_o (noresp_fire)
  );

  // ==========================================================
  // maintenance error bits
  logic [31:0] mcs_set;
  logic [31:0] mcs_err;
  logic [31:0] mcs_clr;

  always_comb
  begin
    mcs_set = '0;
    mcs_set[MCS_MOVB_RD_BIT]  = par_err_i.movb_pb_rd;
    mcs_set[MCS_MOVA_WR_BIT]  = par_err_i.mova_pb_wr;
    mcs_set[MCS_MOV_REG_BIT]  = par_err_i.mov_reg_rd;
    mcs_set[MCS_DP_PB_RD_BIT] = par_err_i.dp_pb_rd;
    mcs_set[MCS_PB_IB_RX_BIT] = par_err_i.port_internal_bus_rx;
    if (ucode_i.set_wr)
      mcs_set[MCS_UCODE_HI:MCS_UCODE_LO] = ucode_i.set_ucode;
    mcs_set[MCS_WRERR_BIT]  = ucode_i.wr_err_irq;
    mcs_set[MCS_RDERR_BIT]  = ucode_i.rd_err_resp;
    mcs_set[MCS_PROCESSOR_ERROR_STATUS_FLAG_BIT]  = processor_error_status_flag_fire;
    mcs_set[MCS_NORESP_BIT] = noresp_fire;
    mcs_set = mcs_set & MCS_ERR_MASK;
    mcs_clr = wr_mcs ? (req_i.wdata & MCS_ERR_MASK) : '0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_mcs
      if (MCS_ERR_MASK[gi])
      begin : g_err
        sticky_bit u_bit (
          .clk_i (clk_i),
          .rst_i (soft_rst),
          .set_i (mcs_set[gi]),
          .clr_i (mcs_clr[gi]),
          .q_o   (mcs_err[gi])
        );
      end
      else
      begin : g_zero
        assign mcs_err[gi] = 1'b0;
      end
    end
  endgenerate

  // bus error summary from processor-class errors
  assign bus_error_summary_o = |mcs_err[MCS_UCODE_HI:MCS_NORESP_BIT];
  assign node_err_summary_o  = |mcs_err;

  // ==========================================================
  // control bits and other registers
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  logic [7:0]  diag_reg;
  logic [7:0]  diag_next;
  logic [31:0] qbb_reg;
  logic [31:0] qbb_next;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    diag_next = diag_reg;
    qbb_next  = qbb_reg;
    if (wr_mcs)
      ctrl_next = req_i.wdata[MCS_IRQ_EN_BIT:MCS_TMR_DIS_BIT];
    if (ucode_i.diag_load)
      diag_next = ucode_i.diag_num;
    if (wr_qbb)
      qbb_next = {1'b0, req_i.wdata[30:0]};
  end

  always_ff @(posedge clk_i or posedge soft_rst)
  begin
    if (soft_rst)
    begin
      ctrl_reg <= 2'h0;
      diag_reg <= 8'h00;
      qbb_reg  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      diag_reg <= diag_next;
      qbb_reg  <= qbb_next;
    end
  end

  assign sanity_hold_o = ctrl_reg[0];

  // ==========================================================
  // port status word
  logic [31:0] psw_reg;
  logic [31:0] psw_next;
  logic [31:0] psw_rd;

  always_comb
  begin
    psw_next = psw_reg;
    if (wr_release)
    begin
      psw_next[PSW_MIF_BIT]        = 1'b0;
      psw_next[PSW_MFQ_EMPTY_BIT]  = 1'b0;
      psw_next[PSW_RESP_AVAIL_BIT] = 1'b0;
    end
    if (ucode_i.enter_enabled)
    begin
      psw_next[PSW_MISC_BIT] = 1'b0;
      psw_next[PSW_MSE_BIT]  = 1'b0;
      psw_next[PSW_DSE_BIT]  = 1'b0;
    end
    if (wr_init || ucode_i.boot_timeout || ucode_i.enter_disabled)
      psw_next[PSW_UNINIT_BIT] = 1'b0;
    if (ucode_i.ucode_init)
      psw_next[PSW_TMR_EXP_BIT] = 1'b0;
    if (sanity_expired_i)
    begin
      psw_next[PSW_TMR_EXP_BIT] = 1'b1;
      psw_next[PSW_UNINIT_BIT]  = 1'b1;
    end
    // microcode sets take priority over clears
    psw_next = psw_next | (ucode_i.psw_set & PSW_SET_MASK);
    psw_next[PSW_SUMMARY_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or posedge soft_rst)
  begin
    if (soft_rst)
      psw_reg <= PSW_RESET;
    else
      psw_reg <= psw_next;
  end

  always_comb
  begin
    psw_rd = psw_reg;
    psw_rd[PSW_SUMMARY_BIT] = |(psw_reg & PSW_SUM_MASK);
  end

  assign status_irq_o = psw_rd[PSW_SUMMARY_BIT] && ctrl_reg[1];

  // ==========================================================
  // read data
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = rdata_reg;
    if (req_i.rd)
    begin
      case (req_i.addr)
        MAINT_CONTROL_STATUS_OFS: rdata_next = mcs_err | {29'h0, ctrl_reg, 1'b0};
        PORT_DIAG_FAIL_TEST_OFS:  rdata_next = {24'h000000, diag_reg};
        PORT_STATUS_WORD_OFS:     rdata_next = psw_rd;
        QUEUE_BLOCK_BASE_OFS:     rdata_next = qbb_reg;
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign rdata_o = rdata_reg;

  // ==========================================================
  // checks
  movb_parity_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    par_err_i.movb_pb_rd |=> mcs_err[MCS_MOVB_RD_BIT])
    else $error("mover b parity flag not set");
  mova_parity_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    par_err_i.mova_pb_wr |=> mcs_err[MCS_MOVA_WR_BIT])
    else $error("mover a parity flag not set");
  movreg_parity_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    par_err_i.mov_reg_rd |=> mcs_err[MCS_MOV_REG_BIT])
    else $error("mover register parity flag not set");
  dp_rd_parity_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    par_err_i.dp_pb_rd |=> mcs_err[MCS_DP_PB_RD_BIT])
    else $error("datapath read parity flag not set");
  ib_rx_parity_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    par_err_i.port_internal_bus_rx |=> mcs_err[MCS_PB_IB_RX_BIT])
    else $error("internal bus parity flag not set");
  ucode_summary_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    (ucode_i.set_wr && |ucode_i.set_ucode) |=> bus_error_summary_o)
    else $error("bus error summary missing");
  write_err_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    ucode_i.wr_err_irq |=> mcs_err[MCS_WRERR_BIT])
    else $error("write error flag not set");
  read_err_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    ucode_i.rd_err_resp |=> mcs_err[MCS_RDERR_BIT])
    else $error("read error flag not set");
  processor_error_status_flag_short_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    $rose(processor_error_signal_i) && !mcs_err[MCS_PROCESSOR_ERROR_STATUS_FLAG_BIT] |->
      !mcs_err[MCS_PROCESSOR_ERROR_STATUS_FLAG_BIT] [*8])
    else $error("processor error flag set too early");
  w1c_clear_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    wr_mcs && req_i.wdata[MCS_MOVB_RD_BIT] && !par_err_i.movb_pb_rd
      |=> !mcs_err[MCS_MOVB_RD_BIT])
    else $error("write one did not clear");
  release_clear_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    wr_release && !ucode_i.psw_set[PSW_MIF_BIT] |=> !psw_reg[PSW_MIF_BIT])
    else $error("interrupt flag not released");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (soft_rst)
    status_irq_o == (ctrl_reg[1] &&
      (psw_reg[PSW_UNINIT_BIT] || |psw_reg[PSW_MISC_BIT:PSW_MFQ_EMPTY_BIT])))
    else $error("interrupt does not follow status and enable");
  init_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    maint_init |=> ##1 (mcs_err == 32'h0 && psw_reg == PSW_RESET))
    else $error("maintenance init left state");
  cov_processor_error_status_flag_c: cover property (@(posedge clk_i) processor_error_status_flag_fire);
  cov_noresp_c: cover property (@(posedge clk_i) noresp_fire);
  cov_irq_c: cover property (@(posedge clk_i) $rose(status_irq_o));
  cov_init_c: cover property (@(posedge clk_i) maint_init);

endmodule : port_maint_status_regs

/* verif/host_model.sv */
module host_model
  import port_maint_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // register bus
  output reg_req_t         req_o,
  input  wire logic [31:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // host register accesses
  initial req_o = '0;

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask : reg_rd

  // ==========================================================
  // driver view of the maintenance word
  // microcode error bits are meaningless once the processor error flag is up
  function automatic logic [31:0] usable(input logic [31:0] mcs);
    usable = mcs[MCS_PROCESSOR_ERROR_STATUS_FLAG_BIT] ? (mcs & ~32'h0000_3f00) : mcs;
  endfunction : usable
endmodule : host_model

/* verif/tb.sv */
module tb
  import port_maint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CP_LIM = 8;
  localparam int NR_LIM = 16;

  logic        clk_i;
  logic        rst_i;
  reg_req_t    req_i;
  logic [31:0] rdata_o;
  par_err_t    par_err_i;
  logic        processor_error_signal_i;
  logic        resp_irq_pending_i;
  logic        resp_irq_ack_i;
  logic        sanity_expired_i;
  ucode_req_t  ucode_i;
  logic        bus_error_summary_o;
  logic        node_err_summary_o;
  logic        status_irq_o;
  logic        sanity_hold_o;
  logic        port_reset_o;
  int          fail_count;
  int          checks_done;

  port_maint_status_regs #(.PROCESSOR_ERROR_STATUS_FLAG_LIMIT(CP_LIM), .NORESP_LIMIT(NR_LIM)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .par_err_i(par_err_i), .processor_error_signal_i(processor_error_signal_i),
    .resp_irq_pending_i(resp_irq_pending_i), .resp_irq_ack_i(resp_irq_ack_i),
    .sanity_expired_i(sanity_expired_i), .ucode_i(ucode_i),
    .bus_error_summary_o(bus_error_summary_o), .node_err_summary_o(node_err_summary_o),
    .status_irq_o(status_irq_o), .sanity_hold_o(sanity_hold_o),
    .port_reset_o(port_reset_o)
  );

  host_model host (.clk_i(clk_i), .req_o(req_i), .rdata_i(rdata_o));

  // ==========================================================
  // clock and helpers
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic lvl(input logic s, input logic e);
    check({31'h0, s}, {31'h0, e});
  endtask : lvl

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.reg_rd(a, d);
    check(d, e);
  endtask : rd_chk

  task automatic uc(input ucode_req_t u);
    @(posedge clk_i);
    ucode_i <= u;
    @(posedge clk_i);
    ucode_i <= '0;
  endtask : uc

  task automatic stim(input logic pe, input logic pd, input logic ak, input int n);
    @(posedge clk_i);
    processor_error_signal_i <= pe;
    resp_irq_pending_i       <= pd;
    resp_irq_ack_i           <= ak;
    repeat (n) @(posedge clk_i);
    {processor_error_signal_i, resp_irq_pending_i, resp_irq_ack_i} <= 3'b000;
  endtask : stim

  // expected status word, summary bit included
  function automatic logic [31:0] psw(input logic [31:0] b);
    psw = b | {|(b & PSW_SUM_MASK), 31'h0};
  endfunction : psw

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [5:0]  v6;
    logic [7:0]  d8;
    logic [31:0] v32;
    bit          seen;
    void'($urandom(10807));
    fail_count = 0;
    checks_done = 0;
    rst_i = 1'b1;
    par_err_i = '0;
    {processor_error_signal_i, resp_irq_pending_i, resp_irq_ack_i} = 3'b000;
    sanity_expired_i = 1'b0;
    ucode_i = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(MAINT_CONTROL_STATUS_OFS, MCS_RESET);
    rd_chk(PORT_STATUS_WORD_OFS, psw(PSW_RESET));
    rd_chk(16'h0004, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_i);
      par_err_i <= par_err_t'(5'h01 << i);
      @(posedge clk_i);
      par_err_i <= '0;
      rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h1 << (MCS_PB_IB_RX_BIT + i));
      lvl(node_err_summary_o, 1'b1);
      host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_0000);
      rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h1 << (MCS_PB_IB_RX_BIT + i));
      host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h1 << (MCS_PB_IB_RX_BIT + i));
      rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0000);
      lvl(node_err_summary_o, 1'b0);
    end
    for (int i = 0; i < 4; i++)
    begin
      v6 = 6'($urandom_range(1, 63));
      uc('{set_wr: 1'b1, set_ucode: v6, default: '0});
      rd_chk(MAINT_CONTROL_STATUS_OFS, {18'h0, v6, 8'h00});
      lvl(bus_error_summary_o, 1'b1);
      host.reg_wr(MAINT_CONTROL_STATUS_OFS, {18'h0, v6, 8'h00});
      rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0000);
      lvl(bus_error_summary_o, 1'b0);
    end
    uc('{wr_err_irq: 1'b1, rd_err_resp: 1'b1, default: '0});
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_00c0);
    host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_0040);
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0080);
    host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_0080);
    // processor error signal: just at the limit, then beyond it
    stim(1'b1, 1'b0, 1'b0, CP_LIM);
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0000);
    stim(1'b1, 1'b0, 1'b0, CP_LIM + 4);
    uc('{set_wr: 1'b1, set_ucode: 6'h3f, default: '0});
    host.reg_rd(MAINT_CONTROL_STATUS_OFS, v32);
    check(v32, 32'h0000_3f20);
    check(host.usable(v32), 32'h0000_0020);
    lvl(bus_error_summary_o, 1'b1);
    host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_3f20);
    // responder interrupt answered, unanswered one cycle short of the limit, then beyond
    stim(1'b0, 1'b1, 1'b1, NR_LIM + 4);
    stim(1'b0, 1'b1, 1'b0, NR_LIM - 1);
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0000);
    stim(1'b0, 1'b1, 1'b0, NR_LIM + 4);
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0010);
    lvl(bus_error_summary_o, 1'b1);
    host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_0016);
    rd_chk(MAINT_CONTROL_STATUS_OFS, 32'h0000_0006);
    lvl(sanity_hold_o, 1'b1);
    lvl(status_irq_o, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      d8 = 8'($urandom);
      uc('{diag_load: 1'b1, diag_num: d8, default: '0});
      rd_chk(PORT_DIAG_FAIL_TEST_OFS, {24'h0, d8});
    end
    host.reg_wr(PORT_DIAG_FAIL_TEST_OFS, 32'hffff_ffff);
    rd_chk(PORT_DIAG_FAIL_TEST_OFS, {24'h0, d8});
    v32 = $urandom;
    host.reg_wr(QUEUE_BLOCK_BASE_OFS, v32);
    rd_chk(QUEUE_BLOCK_BASE_OFS, v32 & 32'h7fff_ffff);
    host.reg_wr(PORT_STATUS_WORD_OFS, 32'hffff_ffff);
    rd_chk(PORT_STATUS_WORD_OFS, psw(PSW_RESET));
    host.reg_wr(PORT_INIT_OFS, $urandom);
    rd_chk(PORT_STATUS_WORD_OFS, 32'h0000_0000);
    lvl(status_irq_o, 1'b0);
    uc('{psw_set: 32'h0000_0103, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, psw(32'h0000_0103));
    lvl(status_irq_o, 1'b1);
    host.reg_wr(STATUS_RELEASE_OFS, $urandom);
    rd_chk(PORT_STATUS_WORD_OFS, 32'h0000_0000);
    uc('{psw_set: 32'h0000_00b0, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, psw(32'h0000_00b0));
    uc('{enter_enabled: 1'b1, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, 32'h0000_0000);
    @(posedge clk_i);
    sanity_expired_i <= 1'b1;
    @(posedge clk_i);
    sanity_expired_i <= 1'b0;
    rd_chk(PORT_STATUS_WORD_OFS, psw(32'h0000_0440));
    uc('{boot_timeout: 1'b1, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, psw(32'h0000_0040));
    uc('{ucode_init: 1'b1, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, 32'h0000_0000);
    uc('{psw_set: 32'h0000_0400, default: '0});
    uc('{enter_disabled: 1'b1, default: '0});
    rd_chk(PORT_STATUS_WORD_OFS, 32'h0000_0000);
    // maintenance init with errors and status pending
    uc('{set_wr: 1'b1, set_ucode: 6'h3f, psw_set: 32'h0000_0080, default: '0});
    host.reg_wr(MAINT_CONTROL_STATUS_OFS, 32'h0000_0001);
    seen = 1'b0;
    repeat (3)
    begin
      #1;
      if (port_reset_o === 1'b1)
        seen = 1'b1;
      @(posedge clk_i);
    end
    lvl(seen, 1'b1);
    rd_chk(MAINT_CONTROL_STATUS_OFS, MCS_RESET);
    rd_chk(PORT_STATUS_WORD_OFS, psw(PSW_RESET));
    lvl(sanity_hold_o, 1'b0);
    lvl(status_irq_o, 1'b0);
    lvl(bus_error_summary_o, 1'b0);
    finish_test();
  end
endmodule : tb
